// File: rtl/afr_params.svh
// constants for the accumulator, flag and register file slice
`ifndef AFR_PARAMS_SVH
`define AFR_PARAMS_SVH
// ***************************************************
// data path
// ***************************************************
`define AFR_MSB 7
`define AFR_BYTE_ZERO 8'h00
`define AFR_BYTE_ONE 8'h01
`define AFR_SEC_CNT 6
`define AFR_SEL_MAIN 3'h6
`define AFR_IDX_PAGE 4
`define AFR_IDX_LOW 5
`define AFR_IN_PORTS 6
`define AFR_OUT_PORTS 8
`define AFR_PC_RESET 16'h0000
`define AFR_PC_ONE 16'h0001
// ***************************************************
// register bus map and fields
// ***************************************************
`define AFR_OFF_CTRL 8'h00
`define AFR_OFF_STAT 8'h04
`define AFR_OFF_BCDE 8'h08
`define AFR_OFF_HLPC 8'h0C
`define AFR_CTRL_RESET 1'b1
`define AFR_RESP_OKAY 2'h0
`define AFR_RESP_SLVERR 2'h2
`endif

// File: rtl/afr_pkg.sv
// types shared by the accumulator, flag and register file slice
package afr_pkg;
   // ***************************************************
   // sequencer operations
   // ***************************************************
   typedef enum logic [3:0] {
      AFR_OP_NOP = 4'b0000,
      AFR_OP_ADD = 4'b0001,
      AFR_OP_SUB = 4'b0010,
      AFR_OP_ROL = 4'b0011,
      AFR_OP_ROR = 4'b0100,
      AFR_OP_ROL_C = 4'b0101,
      AFR_OP_ROR_C = 4'b0110,
      AFR_OP_INC = 4'b0111,
      AFR_OP_DEC = 4'b1000,
      AFR_OP_MEM_RD = 4'b1001,
      AFR_OP_MEM_WR = 4'b1010,
      AFR_OP_PORT_IN = 4'b1011,
      AFR_OP_PORT_OUT = 4'b1100,
      AFR_OP_LOAD = 4'b1101,
      AFR_OP_JUMP = 4'b1110,
      AFR_OP_SPARE = 4'b1111
   } afr_op_t;
endpackage

// File: rtl/afr_datapath.sv
// accumulator, flags and register file datapath with an AXI4-Lite view
`timescale 1ns/1ps
`default_nettype none
`include "afr_params.svh"
module afr_datapath
   import afr_pkg::*;
#(
   parameter int AXI_AW = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // sequencer
   input wire logic op_valid,
   input wire afr_op_t op_code,
   input wire logic [2:0] op_reg,
   input wire logic [7:0] op_data,
   input wire logic [2:0] op_port,
   input wire logic [15:0] op_addr,
   input wire logic fetch_step,
   output logic [15:0] fetch_addr,
   // memory
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // io ports
   input wire logic [47:0] in_port_data,
   output logic [7:0] out_port_data,
   output logic [7:0] out_port_strobe,
   // axi4-lite slave
   input wire logic [AXI_AW-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [AXI_AW-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   // ***************************************************
   // state
   // ***************************************************
   logic [7:0] main_working_register_reg;
   logic [7:0] sec_reg [0:`AFR_SEC_CNT-1];
   logic carry_reg, sign_reg, zero_reg, parity_reg;
   logic [15:0] pc_reg;
   logic run_reg;
   logic rd_pend_reg;
   logic [2:0] rd_dest_reg;
   logic [15:0] mem_addr_reg;
   logic mem_rd_reg, mem_wr_reg;
   logic [7:0] mem_wdata_reg;
   logic [7:0] out_data_reg, out_strobe_reg;
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [AXI_AW-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   // ***************************************************
   // decode
   // ***************************************************
   wire take = op_valid && run_reg;
   wire [7:0] acc = main_working_register_reg;
   wire sec_ok = op_reg < `AFR_SEL_MAIN;
   wire [2:0] sidx = sec_ok ? op_reg : 3'h0;
   wire [7:0] sec_val = sec_reg[sidx];
   wire [7:0] sel_val = (op_reg == `AFR_SEL_MAIN) ? acc : (sec_ok ? sec_val : `AFR_BYTE_ZERO);
   wire [8:0] sum9 = {1'b0, acc} + {1'b0, op_data};
   wire [8:0] dif9 = {1'b0, acc} - {1'b0, op_data};
   wire [7:0] inc_val = sec_val + `AFR_BYTE_ONE;
   wire [7:0] dec_val = sec_val - `AFR_BYTE_ONE;
   wire [15:0] ptr_addr = {sec_reg[`AFR_IDX_PAGE], sec_reg[`AFR_IDX_LOW]};
   wire in_ok = op_port < 3'(`AFR_IN_PORTS);
   wire [7:0] in_sel = in_port_data[op_port*8 +: 8];
   wire do_add = take && op_code == AFR_OP_ADD;
   wire do_sub = take && op_code == AFR_OP_SUB;
   wire do_inc = take && op_code == AFR_OP_INC && sec_ok;
   wire do_dec = take && op_code == AFR_OP_DEC && sec_ok;
   wire do_mrd = take && op_code == AFR_OP_MEM_RD;
   wire do_mwr = take && op_code == AFR_OP_MEM_WR;
   wire do_in = take && op_code == AFR_OP_PORT_IN && in_ok;
   wire do_out = take && op_code == AFR_OP_PORT_OUT;
   wire do_load = take && op_code == AFR_OP_LOAD;
   wire do_jump = take && op_code == AFR_OP_JUMP;

   // ***************************************************
   // main register and flags
   // ***************************************************
   logic [7:0] acc_next;
   logic carry_next;
   logic szp_upd;
   always_comb
   begin
      acc_next = acc;
      carry_next = carry_reg;
      szp_upd = 1'b0;
      if (rd_pend_reg && rd_dest_reg == `AFR_SEL_MAIN)
      begin
         acc_next = mem_rdata;
      end
      else if (take)
      begin
         unique case (op_code)
            AFR_OP_ADD:
            begin
               acc_next = sum9[7:0];
               carry_next = sum9[8];
               szp_upd = 1'b1;
            end
            AFR_OP_SUB:
            begin
               acc_next = dif9[7:0];
               carry_next = dif9[8];
               szp_upd = 1'b1;
            end
            AFR_OP_ROL: acc_next = {acc[6:0], acc[`AFR_MSB]};
            AFR_OP_ROR: acc_next = {acc[0], acc[7:1]};
            AFR_OP_ROL_C:
            begin
               acc_next = {acc[6:0], carry_reg};
               carry_next = acc[`AFR_MSB];
            end
            AFR_OP_ROR_C:
            begin
               acc_next = {carry_reg, acc[7:1]};
               carry_next = acc[0];
            end
            AFR_OP_PORT_IN: acc_next = in_ok ? in_sel : acc;
            AFR_OP_LOAD: acc_next = (op_reg == `AFR_SEL_MAIN) ? op_data : acc;
            // increment and decrement never touch the main register
            AFR_OP_NOP, AFR_OP_INC, AFR_OP_DEC, AFR_OP_MEM_RD, AFR_OP_MEM_WR,
            AFR_OP_PORT_OUT, AFR_OP_JUMP, AFR_OP_SPARE: acc_next = acc;
         endcase
      end
   end

   // sign, zero and parity follow the add, subtract, increment or decrement result of this cycle
   wire [7:0] res_val = (do_inc) ? inc_val : (do_dec ? dec_val : acc_next);
   wire szp_any = szp_upd || do_inc || do_dec;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         main_working_register_reg <= `AFR_BYTE_ZERO;
         carry_reg <= 1'b0;
         sign_reg <= 1'b0;
         zero_reg <= 1'b0;
         parity_reg <= 1'b0;
      end
      else
      begin
         main_working_register_reg <= acc_next;
         carry_reg <= carry_next;
         if (szp_any)
         begin
            sign_reg <= res_val[`AFR_MSB];
            zero_reg <= (res_val == `AFR_BYTE_ZERO);
            parity_reg <= ~^res_val;
         end
      end
   end

   // ***************************************************
   // secondary registers
   // ***************************************************
   wire ret_sec = rd_pend_reg && rd_dest_reg < `AFR_SEL_MAIN;
   wire sec_we = ret_sec || do_inc || do_dec || (do_load && sec_ok);
   wire [2:0] sec_wi = ret_sec ? rd_dest_reg : sidx;
   wire [7:0] sec_wv = ret_sec ? mem_rdata : (do_inc ? inc_val : (do_dec ? dec_val : op_data));

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < `AFR_SEC_CNT; i++)
         begin
            sec_reg[i] <= `AFR_BYTE_ZERO;
         end
      end
      else if (sec_we)
      begin
         sec_reg[sec_wi] <= sec_wv;
      end
   end

   // ***************************************************
   // program counter, memory and ports
   // ***************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_reg <= `AFR_PC_RESET;
         rd_pend_reg <= 1'b0;
         rd_dest_reg <= 3'h0;
         mem_addr_reg <= `AFR_PC_RESET;
         mem_rd_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         mem_wdata_reg <= `AFR_BYTE_ZERO;
         out_data_reg <= `AFR_BYTE_ZERO;
         out_strobe_reg <= `AFR_BYTE_ZERO;
      end
      else
      begin
         if (do_jump)
            pc_reg <= op_addr;
         else if (fetch_step)
            pc_reg <= pc_reg + `AFR_PC_ONE;
         rd_pend_reg <= mem_rd_reg;
         if (do_mrd)
            rd_dest_reg <= op_reg;
         if (do_mrd || do_mwr)
            mem_addr_reg <= ptr_addr;
         mem_rd_reg <= do_mrd;
         mem_wr_reg <= do_mwr;
         if (do_mwr)
            mem_wdata_reg <= sel_val;
         if (do_out)
            out_data_reg <= acc;
         out_strobe_reg <= do_out ? (`AFR_BYTE_ONE << op_port) : `AFR_BYTE_ZERO;
      end
   end

   // ***************************************************
   // axi4-lite slave
   // ***************************************************
   wire aw_hs = s_awvalid && awready_reg;
   wire w_hs = s_wvalid && wready_reg;
   wire wr_go = !awready_reg && !wready_reg && !bvalid_reg;
   wire wr_ctrl = awaddr_reg == AXI_AW'(`AFR_OFF_CTRL);
   wire ar_hs = s_arvalid && arready_reg;
   wire [31:0] stat_word = {20'h0, carry_reg, sign_reg, zero_reg, parity_reg, acc};
   wire [31:0] bcde_word = {sec_reg[0], sec_reg[1], sec_reg[2], sec_reg[3]};
   wire [31:0] hlpc_word = {pc_reg, sec_reg[`AFR_IDX_PAGE], sec_reg[`AFR_IDX_LOW]};
   wire rd_map = s_araddr == AXI_AW'(`AFR_OFF_CTRL) || s_araddr == AXI_AW'(`AFR_OFF_STAT)
      || s_araddr == AXI_AW'(`AFR_OFF_BCDE) || s_araddr == AXI_AW'(`AFR_OFF_HLPC);
   wire [31:0] rd_word = (s_araddr == AXI_AW'(`AFR_OFF_CTRL)) ? {31'h0, run_reg} :
      (s_araddr == AXI_AW'(`AFR_OFF_STAT)) ? stat_word :
      (s_araddr == AXI_AW'(`AFR_OFF_BCDE)) ? bcde_word :
      (s_araddr == AXI_AW'(`AFR_OFF_HLPC)) ? hlpc_word : 32'h0;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= `AFR_RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         run_reg <= `AFR_CTRL_RESET;
      end
      else
      begin
         if (aw_hs)
         begin
            awready_reg <= 1'b0;
            awaddr_reg <= s_awaddr;
         end
         if (w_hs)
         begin
            wready_reg <= 1'b0;
            wdata_reg <= s_wdata;
            wstrb_reg <= s_wstrb;
         end
         if (wr_go)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ctrl ? `AFR_RESP_OKAY : `AFR_RESP_SLVERR;
            if (wr_ctrl && wstrb_reg[0])
               run_reg <= wdata_reg[0];
         end
         if (bvalid_reg && s_bready)
         begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= `AFR_RESP_OKAY;
      end
      else
      begin
         if (ar_hs)
         begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_map ? `AFR_RESP_OKAY : `AFR_RESP_SLVERR;
         end
         else if (rvalid_reg && s_rready)
         begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign fetch_addr = pc_reg;
   assign mem_addr = mem_addr_reg;
   assign mem_rd = mem_rd_reg;
   assign mem_wr = mem_wr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign out_port_data = out_data_reg;
   assign out_port_strobe = out_strobe_reg;
   assign s_awready = awready_reg;
   assign s_wready = wready_reg;
   assign s_bvalid = bvalid_reg;
   assign s_bresp = bresp_reg;
   assign s_arready = arready_reg;
   assign s_rvalid = rvalid_reg;
   assign s_rdata = rdata_reg;
   assign s_rresp = rresp_reg;

   // ***************************************************
   // assertions
   // ***************************************************
   a_carry_arith: assert property (@(posedge clk) disable iff (!rst_n)
      (do_add && !rd_pend_reg) |=> carry_reg == $past(sum9[8]) && acc == $past(sum9[7:0]))
      else $error("carry or sum wrong after add");
   a_rot_nine: assert property (@(posedge clk) disable iff (!rst_n)
      (take && op_code == AFR_OP_ROR_C && !rd_pend_reg)
      |=> {acc, carry_reg} == $past({carry_reg, acc}))
      else $error("nine bit rotate wrong");
   a_sign_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (do_sub && !rd_pend_reg) |=> sign_reg == acc[7] && zero_reg == (acc == 8'h00))
      else $error("sign or zero flag disagrees with result");
   a_parity_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (do_add && !rd_pend_reg) |=> parity_reg == ~^acc)
      else $error("parity flag disagrees with result");
   a_inc_flags: assert property (@(posedge clk) disable iff (!rst_n)
      do_inc |=> zero_reg == ($past(inc_val) == 8'h00) && sign_reg == $past(inc_val[7]))
      else $error("increment flags wrong");
   a_incdec_carry: assert property (@(posedge clk) disable iff (!rst_n)
      (do_inc || do_dec) |=> $stable(carry_reg))
      else $error("carry changed on increment or decrement");
   a_ptr_addr: assert property (@(posedge clk) disable iff (!rst_n)
      (do_mrd || do_mwr) |=> mem_addr == $past(ptr_addr) && (mem_rd || mem_wr))
      else $error("pointer address wrong");
   a_port_out: assert property (@(posedge clk) disable iff (!rst_n)
      do_out |=> out_port_data == $past(acc) && out_port_strobe == (8'h01 << $past(op_port))
      ##1 out_port_strobe == 8'h00 || $past(do_out))
      else $error("output port transfer wrong");
   a_port_in: assert property (@(posedge clk) disable iff (!rst_n)
      (do_in && !rd_pend_reg) |=> acc == $past(in_sel))
      else $error("input port not loaded into main register");
   a_pc_step: assert property (@(posedge clk) disable iff (!rst_n)
      (fetch_step && !do_jump) |=> fetch_addr == $past(pc_reg) + 16'h0001)
      else $error("program counter did not step");
endmodule
`default_nettype wire

// File: verification/afr_mem_model.sv
// memory partner model for the accumulator, flag and register slice
`timescale 1ns/1ps
`default_nettype none
module afr_mem_model (
   // clock
   input wire logic clk,
   // memory side of the datapath
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] store [0:65535];
   initial
   begin
      mem_rdata = 8'h5A;
   end
   // read data stands one cycle, then turns over so stale data never matches
   always @(posedge clk)
   begin
      if (mem_rd)
         mem_rdata <= store[mem_addr];
      else
         mem_rdata <= ~mem_rdata;
      if (mem_wr)
         store[mem_addr] <= mem_wdata;
   end
endmodule
`default_nettype wire

// File: verification/accumulator_flags_regfile_tb.sv
// self-checking bench for the accumulator, flag and register slice
`timescale 1ns/1ps
`default_nettype none
`include "afr_params.svh"
module accumulator_flags_regfile_tb
   import afr_pkg::*;
;
   logic clk, rst_n, op_valid, fetch_step, mem_rd, mem_wr;
   afr_op_t op_code;
   logic [2:0] op_reg, op_port;
   logic [7:0] op_data, mem_wdata, mem_rdata, out_port_data, out_port_strobe;
   logic [15:0] op_addr, fetch_addr, mem_addr;
   logic [47:0] in_port_data;
   logic [7:0] s_awaddr, s_araddr;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp;
   int miscompares, cmp_count;
   logic [7:0] m_acc;
   logic [7:0] m_reg [0:5];
   logic m_c, m_s, m_z, m_p, m_run;
   logic [15:0] m_pc;
   afr_op_t dc [13] = '{AFR_OP_LOAD, AFR_OP_ADD, AFR_OP_SUB, AFR_OP_LOAD, AFR_OP_ROR,
      AFR_OP_ROL, AFR_OP_ROL_C, AFR_OP_ROR_C, AFR_OP_LOAD, AFR_OP_INC, AFR_OP_DEC,
      AFR_OP_INC, AFR_OP_DEC};
   logic [2:0] dr [13] = '{3'h6, 3'h0, 3'h0, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
      3'h0, 3'h6, 3'h5};
   logic [7:0] dd [13] = '{8'hFF, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
      8'h00, 8'h00, 8'h00, 8'h00};
   afr_op_t ro [10] = '{AFR_OP_ADD, AFR_OP_SUB, AFR_OP_ROL, AFR_OP_ROR, AFR_OP_ROL_C,
      AFR_OP_ROR_C, AFR_OP_INC, AFR_OP_DEC, AFR_OP_LOAD, AFR_OP_PORT_IN};

   afr_datapath afr_datapath_i (.clk, .rst_n, .op_valid, .op_code, .op_reg, .op_data,
      .op_port, .op_addr, .fetch_step, .fetch_addr, .mem_addr, .mem_rd, .mem_wr,
      .mem_wdata, .mem_rdata, .in_port_data, .out_port_data, .out_port_strobe,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
      .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
      .s_rresp, .s_rvalid, .s_rready);
   afr_mem_model afr_mem_model_i (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
      .mem_rdata);

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic results();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h, seen %h", n, e, g);
         miscompares++;
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 50)
      begin
         $display("unexpected bus answer: expected within 50 cycles, seen none");
         miscompares++;
         results();
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                         output logic [1:0] r);
      int n = 0;
      @(posedge clk);
      s_awaddr <= a;
      s_awvalid <= 1'b1;
      s_wdata <= d;
      s_wstrb <= st;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_awready === 1'b1)
            s_awvalid <= 1'b0;
         if (s_wready === 1'b1)
            s_wvalid <= 1'b0;
      end while (s_bvalid !== 1'b1 && n < 50);
      tmo(n);
      r = s_bresp;
      s_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n = 0;
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_arready === 1'b1)
            s_arvalid <= 1'b0;
      end while (s_rvalid !== 1'b1 && n < 50);
      tmo(n);
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
   endtask

   task automatic szp(input logic [7:0] v);
      m_s = v[7];
      m_z = (v == 8'h00);
      m_p = ~^v;
   endtask

   // expected effect of one sequencer operation
   task automatic model(input afr_op_t c, input logic [2:0] r, input logic [7:0] d,
                        input logic [2:0] k);
      if (!m_run)
         return;
      case (c)
         AFR_OP_ADD: {m_c, m_acc} = {1'b0, m_acc} + {1'b0, d};
         AFR_OP_SUB: {m_c, m_acc} = {d > m_acc, m_acc - d};
         AFR_OP_ROL: m_acc = {m_acc[6:0], m_acc[7]};
         AFR_OP_ROR: m_acc = {m_acc[0], m_acc[7:1]};
         AFR_OP_ROL_C: {m_c, m_acc} = {m_acc, m_c};
         AFR_OP_ROR_C: {m_acc, m_c} = {m_c, m_acc};
         AFR_OP_INC: if (r < 3'h6) m_reg[r] = m_reg[r] + 8'h01;
         AFR_OP_DEC: if (r < 3'h6) m_reg[r] = m_reg[r] - 8'h01;
         AFR_OP_LOAD: if (r == 3'h6) m_acc = d; else if (r < 3'h6) m_reg[r] = d;
         AFR_OP_PORT_IN: if (k < 3'h6) m_acc = in_port_data[8*k +: 8];
         AFR_OP_JUMP: m_pc = op_addr;
         default: ;
      endcase
      if (c == AFR_OP_ADD || c == AFR_OP_SUB)
         szp(m_acc);
      if ((c == AFR_OP_INC || c == AFR_OP_DEC) && r < 3'h6)
         szp(m_reg[r]);
   endtask

   task automatic op(input afr_op_t c, input logic [2:0] r, input logic [7:0] d,
                     input logic [2:0] k);
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_reg <= r;
      op_data <= d;
      op_port <= k;
      op_addr <= 16'($urandom);
      in_port_data <= {16'($urandom), $urandom};
      @(posedge clk);
      op_valid <= 1'b0;
      model(c, r, d, k);
   endtask

   task automatic chk_all();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(`AFR_OFF_STAT, d, r);
      chk("stat", {20'h0, m_c, m_s, m_z, m_p, m_acc}, d);
      axi_rd(`AFR_OFF_BCDE, d, r);
      chk("bcde", {m_reg[0], m_reg[1], m_reg[2], m_reg[3]}, d);
      axi_rd(`AFR_OFF_HLPC, d, r);
      chk("hlpc", {m_pc, m_reg[4], m_reg[5]}, d);
   endtask

   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] h, l, v;
      logic [2:0] src, dst;
      {rst_n, op_valid, fetch_step, s_awvalid, s_wvalid, s_bready, s_arvalid} = '0;
      {op_reg, op_port, op_data, op_addr, in_port_data, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
      op_code = AFR_OP_NOP;
      {m_acc, m_c, m_s, m_z, m_p, m_pc} = '0;
      m_reg = '{default: 8'h00};
      m_run = 1'b1;
      void'($urandom(32'h6024));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      axi_rd(`AFR_OFF_CTRL, d, r);
      chk("ctrl_reset", 32'h1, d);
      chk_all();
      for (int i = 0; i < 13; i++)
      begin
         op(dc[i], dr[i], dd[i], 3'h0);
         chk_all();
      end
      for (int i = 0; i < 60; i++)
      begin
         op(ro[$urandom_range(0, 9)], 3'($urandom), 8'($urandom), 3'($urandom));
         chk_all();
      end
      for (int k = 0; k < 8; k++)
      begin
         op(AFR_OP_PORT_IN, 3'h0, 8'h00, 3'(k));
         chk_all();
         op(AFR_OP_PORT_OUT, 3'h0, 8'h00, 3'(k));
         #1;
         chk("out_data", {24'h0, m_acc}, {24'h0, out_port_data});
         chk("out_strobe", 32'h1 << k, {24'h0, out_port_strobe});
         @(posedge clk);
         #1;
         chk("strobe_end", 32'h0, {24'h0, out_port_strobe});
      end
      for (int i = 0; i < 4; i++)
      begin
         h = 8'($urandom);
         l = 8'($urandom);
         v = 8'($urandom);
         src = (i == 0) ? 3'h6 : 3'($urandom_range(0, 3));
         dst = (src == 3'h6) ? 3'h0 : 3'h6;
         op(AFR_OP_LOAD, 3'h4, h, 3'h0);
         op(AFR_OP_LOAD, 3'h5, l, 3'h0);
         op(AFR_OP_LOAD, src, v, 3'h0);
         op(AFR_OP_MEM_WR, src, 8'h00, 3'h0);
         #1;
         chk("mem_wr", {h, l, 8'h01, v}, {mem_addr, 7'h0, mem_wr, mem_wdata});
         op(AFR_OP_MEM_RD, dst, 8'h00, 3'h0);
         #1;
         chk("mem_rd", {h, l, 16'h0001}, {mem_addr, 15'h0, mem_rd});
         repeat (2) @(posedge clk);
         if (dst == 3'h6)
            m_acc = v;
         else
            m_reg[dst] = v;
         chk_all();
      end
      @(posedge clk);
      fetch_step <= 1'b1;
      repeat (5) @(posedge clk);
      fetch_step <= 1'b0;
      m_pc = m_pc + 16'h0005;
      #1;
      chk("fetch_addr", {16'h0, m_pc}, {16'h0, fetch_addr});
      op(AFR_OP_JUMP, 3'h0, 8'h00, 3'h0);
      #1;
      chk("jump_addr", {16'h0, m_pc}, {16'h0, fetch_addr});
      axi_wr(`AFR_OFF_CTRL, 32'h0, 4'hF, r);
      chk("ctrl_wr", 32'h0, {30'h0, r});
      m_run = 1'b0;
      op(AFR_OP_ADD, 3'h0, 8'h11, 3'h0);
      chk_all();
      axi_wr(`AFR_OFF_CTRL, 32'h1, 4'h0, r);
      axi_rd(`AFR_OFF_CTRL, d, r);
      chk("ctrl_strb", 32'h0, d);
      axi_wr(`AFR_OFF_CTRL, 32'h1, 4'h1, r);
      m_run = 1'b1;
      axi_wr(`AFR_OFF_STAT, 32'hFFFF_FFFF, 4'hF, r);
      chk("ro_wr_resp", {30'h0, `AFR_RESP_SLVERR}, {30'h0, r});
      axi_wr(8'h10, 32'h0, 4'hF, r);
      chk("unmapped_wr", {30'h0, `AFR_RESP_SLVERR}, {30'h0, r});
      axi_rd(8'h40, d, r);
      chk("unmapped_rd", {30'h0, `AFR_RESP_SLVERR}, {30'h0, r});
      chk("unmapped_data", 32'h0, d);
      op(AFR_OP_SUB, 3'h0, 8'($urandom), 3'h0);
      chk_all();
      results();
   end
endmodule
`default_nettype wire
